/* File: verif/ctrl_model.sv */
// Purpose: controller model issuing decoded mode and write commands
// Assumes: outputs change at the falling edge
// Notes: banks stay idle; reserved codes and range changes in training are issued too
`timescale 1ns/100ps
module ctrl_model (
    // clock
    input wire i_clk,
    // commands
    output reg o_mrs,
    output reg [2:0] o_sel,
    output reg [7:0] o_data,
    output reg o_wr,
    output reg o_lane
);
    initial {o_mrs, o_sel, o_data, o_wr, o_lane} = 14'h0000;
    // dropped data shows its inverse so no stale value passes
    task mrs(input [2:0] s, input [7:0] d);
        begin
            o_mrs = 1'b1;
            o_sel = s;
            o_data = d;
            @(negedge i_clk);
            o_mrs = 1'b0;
            o_data = ~d;
            // a free edge between commands so no strobe toggles twice in a step
            @(negedge i_clk);
        end
    endtask
    // write pulse only, data not modelled
    task wr;
        begin
            o_wr = 1'b1;
            @(negedge i_clk);
            o_wr = 1'b0;
        end
    endtask
    task lane(input v);
        o_lane = v;
    endtask
endmodule // ctrl_model

/* File: verif/dq_reference_training_mode_tb.sv */
// Purpose: self-checking bench of the reference training block
// Assumes: inputs change at the falling edge
// Notes: every wait is a fixed window, so nothing can hang
`timescale 1ns/100ps
module dq_reference_training_mode_tb;
    reg i_clk = 1'b0;
    reg i_rst_n = 1'b0;
    wire mrs, wr, ln, act, rg, ew, xw, dw, rv, rr, per_device_addressing_mode, rs, vio;
    wire [2:0] sel;
    wire [7:0] dat;
    wire [5:0] lv, rl;
    integer err_total = 0;
    integer n_compared = 0;
    initial forever #10 i_clk = ~i_clk;
    ctrl_model m (.i_clk(i_clk), .o_mrs(mrs), .o_sel(sel), .o_data(dat), .o_wr(wr),
        .o_lane(ln));
    dq_reference_training_mode dq_reference_training_mode_i (.i_clk(i_clk),
        .i_rst_n(i_rst_n), .i_mrs(mrs), .i_mr_sel(sel), .i_mr_data(dat), .i_write_cmd(wr),
        .i_lane_zero(ln), .o_train_active(act), .o_train_range(rg), .o_train_level(lv),
        .o_entry_wait(ew), .o_exit_wait(xw), .o_dummy_write(dw), .o_ref_valid(rv),
        .o_ref_range(rr), .o_ref_level(rl), .o_pda_mode(per_device_addressing_mode), .o_level_reserved(rs),
        .o_range_violation(vio));
    task chk(input [8*6:1] nm, input [7:0] e, input [7:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("unexpected %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    // cycles a wait flag stays high within a fixed window
    task wait_len(input w);
        integer n, k;
        begin
            n = 0;
            // counting starts at the current sample
            for (k = 0; k < 20; k = k + 1) begin
                if ((w ? xw : ew) === 1'b1) n = n + 1;
                @(negedge i_clk);
            end
            chk("wait", 8'h08, n[7:0]);
        end
    endtask
    task t_range(input r);
        begin
            m.mrs(3'h6, {1'b1, r, 6'h15});
            chk("range", r, rg);
            chk("level", r ? 8'h32 : 8'h00, lv);
            wait_len(1'b0);
            m.wr;
            if (!r) chk("dummy", 8'h01, dw);
            m.mrs(3'h6, {1'b1, r, 6'h33});
            chk("resv", 8'h01, rs);
            m.mrs(3'h6, {1'b1, r, 6'h00});
            m.mrs(3'h6, {1'b1, ~r, 6'h32});
            chk("viol", 8'h01, vio);
            chk("resv", 8'h00, rs);
            repeat (4) @(negedge i_clk);
            m.mrs(3'h6, 8'h3F);
            chk("active", 8'h00, act);
            chk("refvld", 8'h01, rv);
            chk("reflv", 8'h32, rl);
            chk("refrg", r, rr);
            wait_len(1'b1);
            m.mrs(3'h6, 8'h55);
            chk("level", 8'h32, lv);
            chk("refrg", r, rr);
            $display("range test done");
        end
    endtask
    task t_pda;
        begin
            m.mrs(3'h3, 8'h10);
            chk("pda", 8'h01, per_device_addressing_mode);
            m.lane(1'b1);
            repeat (3) @(negedge i_clk);
            m.mrs(3'h6, 8'h80);
            chk("active", 8'h00, act);
            m.lane(1'b0);
            repeat (3) @(negedge i_clk);
            m.mrs(3'h6, 8'h80);
            chk("active", 8'h01, act);
            wait_len(1'b0);
            m.mrs(3'h6, 8'h00);
            chk("active", 8'h00, act);
            wait_len(1'b1);
            m.mrs(3'h3, 8'h00);
            chk("pda", 8'h00, per_device_addressing_mode);
            $display("addressing test done");
        end
    endtask
    task close_out;
        begin
            $display("compared %0d mismatched %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    initial begin
        repeat (4) @(negedge i_clk);
        i_rst_n = 1'b1;
        chk("refvld", 8'h00, rv);
        t_range(1'b0);
        t_range(1'b1);
        t_pda;
        close_out;
    end
endmodule // dq_reference_training_mode_tb

/* File: verif/vref_train_assertions.sv */
// Purpose: port checks of the reference training block
// Assumes: one clock domain, bound to the block top
// Notes: qualified commands checked with addressing mode off
`timescale 1ns/100ps
module vref_train_chk (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // command
    input wire i_mrs,
    input wire [2:0] i_mr_sel,
    input wire [7:0] i_mr_data,
    input wire i_lane_zero,
    // state
    input wire o_train_active,
    input wire o_train_range,
    input wire [5:0] o_train_level,
    input wire o_entry_wait,
    input wire o_ref_valid,
    input wire o_ref_range,
    input wire [5:0] o_ref_level,
    input wire o_pda_mode
);
    // training command that executes unqualified
    wire t6 = i_mrs && i_mr_sel == 3'h6 && !o_pda_mode;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    train_entry_a: assert property (
        t6 && i_mr_data[7] && !o_train_active |=> o_train_active
        && o_train_range == $past(i_mr_data[6])) else $error("entry");
    entry_wait_a: assert property (
        t6 && i_mr_data[7] && !o_train_active |=> !o_entry_wait ##1
        o_entry_wait [*8] ##1 !o_entry_wait) else $error("entry wait");
    level_write_a: assert property (
        t6 && i_mr_data[7] && o_train_active |=> $stable(o_train_range)
        && o_train_level == $past(i_mr_data[5:0])) else $error("level");
    keep_bits_a: assert property (
        t6 && !i_mr_data[7] |=> $stable(o_train_level)
        && $stable(o_train_range)) else $error("bits changed");
    exit_apply_a: assert property (
        t6 && !i_mr_data[7] && o_train_active |=> !o_train_active && o_ref_valid
        && o_ref_level == $past(o_train_level) && o_ref_range == $past(o_train_range))
        else $error("exit");
    ref_hold_a: assert property (
        !$past(o_train_active) || o_train_active |-> $stable(o_ref_level)
        && $stable(o_ref_range)) else $error("ref moved");
    pda_set_a: assert property (
        i_mrs && i_mr_sel == 3'h3 && !o_pda_mode |=> o_pda_mode == $past(i_mr_data[4]))
        else $error("pda");
    lane_gate_a: assert property (
        i_mrs && i_mr_sel == 3'h6 && o_pda_mode && i_lane_zero && $past(i_lane_zero)
        && $past(i_lane_zero, 2) |=> $stable(o_train_active)) else $error("lane");
endmodule // vref_train_chk
bind dq_reference_training_mode vref_train_chk vref_train_chk_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_mrs(i_mrs), .i_mr_sel(i_mr_sel),
    .i_mr_data(i_mr_data), .i_lane_zero(i_lane_zero), .o_pda_mode(o_pda_mode),
    .o_train_active(o_train_active), .o_train_range(o_train_range),
    .o_train_level(o_train_level), .o_entry_wait(o_entry_wait), .o_ref_valid(o_ref_valid),
    .o_ref_range(o_ref_range), .o_ref_level(o_ref_level));

/* File: verilog/dq_reference_training_mode.v */
// Function
// - bit 7 enables training, bit 6 picks range 1 or range 2
// - six-bit code steps the level; codes 0x33 to 0x3F are reserved
// - a write with bit 7 low leaves bits 6 to 0 unchanged
// - dummy writes before the first level change are accepted
// - on exit apply range and code of last training write; the range applied is the one stored at entry
// - feature bit 4 enables per-device addressing, default zero
// - in that mode mode commands execute only when lane zero is low
//
// Purpose: training-mode control of the internal dq input reference level
// Assumes: commands are decoded upstream and arrive synchronous to i_clk
// Notes: lane zero sample arrives from a data capture path in another domain
`timescale 1ns/100ps
`include "vref_train_defs.vh"
module dq_reference_training_mode (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // decoded command
    input wire i_mrs,
    input wire [`MR_SEL_W-1:0] i_mr_sel,
    input wire [7:0] i_mr_data,
    input wire i_write_cmd,
    input wire i_lane_zero,
    // training state
    output reg o_train_active,
    output reg o_train_range,
    output reg [`LEVEL_W-1:0] o_train_level,
    output reg o_entry_wait,
    output reg o_exit_wait,
    output reg o_dummy_write,
    // applied reference
    output reg o_ref_valid,
    output reg o_ref_range,
    output reg [`LEVEL_W-1:0] o_ref_level,
    // per-device addressing and errors
    output reg o_pda_mode,
    output reg o_level_reserved,
    output reg o_range_violation
);
    // ************************************************************
    // lane zero synchroniser
    // ************************************************************
    // lane zero comes from the data capture path, so it is treated as async
    // resets high: with addressing on, nothing executes for two edges
    reg lane_meta_ff;
    reg lane_sync_ff;

    // first stage read only by the second stage
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lane_meta_ff <= 1'h1;
            lane_sync_ff <= 1'h1;
        end else begin
            lane_meta_ff <= i_lane_zero;
            lane_sync_ff <= lane_meta_ff;
        end
    end

    // ************************************************************
    // command qualification
    // ************************************************************
    wire mrs_exec;
    wire train_wr;
    wire feat_wr;
    wire enter_cmd;
    wire level_cmd;
    wire exit_cmd;
    wire timer_busy;

    // a command that loses qualification changes no state at all
    // with per-device addressing, a high lane zero drops the command
    assign mrs_exec = i_mrs & (~o_pda_mode | ~lane_sync_ff);
    assign train_wr = mrs_exec & (i_mr_sel == `MR_SEL_TRAIN);
    assign feat_wr = mrs_exec & (i_mr_sel == `MR_SEL_FEATURE);
    // bit 7 and the current mode split one register write three ways
    // bit 7 low while idle is dropped: the low bits are never written
    assign enter_cmd = train_wr & i_mr_data[`TRAIN_EN_BIT] & ~o_train_active;
    assign level_cmd = train_wr & i_mr_data[`TRAIN_EN_BIT] & o_train_active;
    assign exit_cmd = train_wr & ~i_mr_data[`TRAIN_EN_BIT] & o_train_active;

    // ************************************************************
    // feature register bit
    // ************************************************************
    // only bit 4 is kept; the other feature bits belong elsewhere
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pda_mode <= `PDA_RESET;
        end else if (feat_wr) begin
            o_pda_mode <= i_mr_data[`PDA_EN_BIT];
        end
    end

    // ************************************************************
    // training register and mode state
    // ************************************************************
    reg nxt_active;
    reg nxt_range;
    reg [`LEVEL_W-1:0] nxt_level;
    reg level_seen_ff;
    reg nxt_level_seen;

    // range stored only on entry; level ignored then
    // the level field of the entry command never reaches o_train_level
    // limitation: the range bit of a level write is ignored, only flagged
    always @* begin
        nxt_active = o_train_active;
        nxt_range = o_train_range;
        nxt_level = o_train_level;
        nxt_level_seen = level_seen_ff;
        if (enter_cmd) begin
            nxt_active = 1'h1;
            nxt_range = i_mr_data[`TRAIN_RANGE_BIT];
            nxt_level_seen = 1'h0;
        end else if (level_cmd) begin
            nxt_level = i_mr_data[`LEVEL_W-1:0];
            nxt_level_seen = 1'h1;
        end else if (exit_cmd) begin
            nxt_active = 1'h0; // low bits untouched
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_train_active <= 1'h0;
            o_train_range <= 1'h0;
            o_train_level <= 6'h00;
            level_seen_ff <= 1'h0;
        end else begin
            o_train_active <= nxt_active;
            o_train_range <= nxt_range;
            o_train_level <= nxt_level;
            level_seen_ff <= nxt_level_seen;
        end
    end

    // ************************************************************
    // applied reference
    // ************************************************************
    // latched only at exit so mid-training codes never reach the receivers
    // trade-off: one cycle of latency at exit against a steady reference
    // o_ref_valid stays low until the first exit, so no code is assumed
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ref_valid <= 1'h0;
            o_ref_range <= 1'h0;
            o_ref_level <= 6'h00;
        end else if (exit_cmd) begin
            o_ref_valid <= 1'h1;
            o_ref_range <= o_train_range;
            o_ref_level <= o_train_level;
        end
    end

    // ************************************************************
    // flags
    // ************************************************************
    // reserved code and range change are flagged, not blocked
    // reserved check runs on the stored code, hence one cycle late
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_level_reserved <= 1'h0;
            o_range_violation <= 1'h0;
            o_dummy_write <= 1'h0;
        end else begin
            o_level_reserved <= (o_train_level > `LEVEL_MAX);
            if (enter_cmd) begin
                o_range_violation <= 1'h0;
            end else if (level_cmd & (i_mr_data[`TRAIN_RANGE_BIT] != o_train_range)) begin
                o_range_violation <= 1'h1;
            end
            // write before first level step after entry is a dummy
            o_dummy_write <= i_write_cmd & o_train_active & ~level_seen_ff;
        end
    end

    // ************************************************************
    // entry and exit waits
    // ************************************************************
    reg wait_is_exit_ff;
    wire [`WAIT_W-1:0] wait_count;

    // both waits share one timer; they never overlap in a legal flow
    // an exit during the entry wait restarts the timer with the exit count
    assign wait_count = exit_cmd ? `EXIT_WAIT_CYC : `ENTRY_WAIT_CYC;

    wait_timer wait_timer_i (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_load(enter_cmd | exit_cmd),
        .i_count(wait_count),
        .o_busy(timer_busy)
    );

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_is_exit_ff <= 1'h0;
        end else if (enter_cmd | exit_cmd) begin
            wait_is_exit_ff <= exit_cmd;
        end
    end

    // status for the controller side; a cycle behind the timer
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_entry_wait <= 1'h0;
            o_exit_wait <= 1'h0;
        end else begin
            o_entry_wait <= timer_busy & ~wait_is_exit_ff;
            o_exit_wait <= timer_busy & wait_is_exit_ff;
        end
    end
endmodule // dq_reference_training_mode

/* File: verilog/vref_train_defs.vh */
// Purpose: constants for the dq input reference training block
// Assumes: included by bare name, definitions only
// Notes: mode register fields and timing counts at 50 MHz
`ifndef VREF_TRAIN_DEFS_VH
`define VREF_TRAIN_DEFS_VH
// mode register select codes
`define MR_SEL_W 3
`define MR_SEL_FEATURE 3'h3
`define MR_SEL_TRAIN 3'h6
// training register fields
`define TRAIN_EN_BIT 7
`define TRAIN_RANGE_BIT 6
`define LEVEL_W 6
`define LEVEL_MAX 6'h32
// feature register field
`define PDA_EN_BIT 4
`define PDA_RESET 1'h0
// waits in ns and derived counts at 20 ns per cycle
`define CLK_PERIOD_NS 20
`define ENTRY_WAIT_NS 150
`define EXIT_WAIT_NS 150
// 150 ns rounded up to whole 20 ns cycles, sized to the timer width
`define ENTRY_WAIT_CYC 8'h08
`define EXIT_WAIT_CYC 8'h08
`define WAIT_W 8
`endif

/* File: verilog/wait_timer.v */
// Purpose: one-shot down counter for training entry and exit waits
// Assumes: single clock, async active-low reset
// Notes: load restarts the count; busy is decoded from the count register
`timescale 1ns/100ps
`include "vref_train_defs.vh"
module wait_timer (
    // clock and reset
    input wire i_clk,
    input wire i_rst_n,
    // control
    input wire i_load,
    input wire [`WAIT_W-1:0] i_count,
    // status
    output wire o_busy
);
    reg [`WAIT_W-1:0] cnt_ff;
    reg [`WAIT_W-1:0] nxt_cnt;

    // load wins over the running count
    always @* begin
        nxt_cnt = cnt_ff;
        if (i_load) begin
            nxt_cnt = i_count;
        end else if (cnt_ff != 8'h00) begin
            nxt_cnt = cnt_ff - 8'h01;
        end
    end

    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign o_busy = (cnt_ff != 8'h00);
endmodule // wait_timer
